// [src/acbx_params.svh]
// Constants for the add/and/branch-on-carry execution slice
`ifndef ACBX_PARAMS_SVH
`define ACBX_PARAMS_SVH

`define ACBX_HI_ADD_LIT 8'h0F
`define ACBX_HI_AND_LIT 8'h0B
`define ACBX_HI_BR_C 8'hE2
`define ACBX_TOP_ADD_REG 6'h09
`define ACBX_TOP_ADDC_REG 6'h08
`define ACBX_TOP_AND_REG 6'h05
`define ACBX_DEST_BIT 9
`define ACBX_BANK_BIT 8

`define ACBX_FLG_C 0
`define ACBX_FLG_DC 1
`define ACBX_FLG_Z 2
`define ACBX_FLG_OV 3
`define ACBX_FLG_N 4
`define ACBX_LOGIC_MASK 5'h14

`define ACBX_ACC_SPLIT 8'h80
`define ACBX_ACC_LO_BANK 4'h0
`define ACBX_ACC_HI_BANK 4'hF
`define ACBX_PC_STEP 32'h0000_0002

`define ACBX_REG_WORK 8'h00
`define ACBX_REG_FLAGS 8'h04
`define ACBX_REG_BANK 8'h08
`define ACBX_REG_PC 8'h0C
`define ACBX_REG_EXEC 8'h10
`define ACBX_EXEC_BUSY 0
`define ACBX_EXEC_TAKEN 1
`define ACBX_EXEC_UNK 2

`define ACBX_WORK_RST 8'h00
`define ACBX_FLAGS_RST 5'h00
`define ACBX_BANK_RST 4'h0
`define ACBX_PC_RST 32'h0000_0000
`define ACBX_RESP_OKAY 2'h0
`define ACBX_RESP_SLVERR 2'h2

`endif

// [src/acbx_pkg.sv]
// Types for the add/and/branch-on-carry execution slice
package acbx_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_NOPC = 2'b10
  } acbx_state_t;
  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b10,
    PH_Q4 = 2'b11
  } acbx_phase_t;
  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_ADD_LITERAL = 3'b001,
    OP_ADD_REG = 3'b010,
    OP_ADD_REG_CARRY = 3'b011,
    OP_AND_LITERAL = 3'b100,
    OP_AND_REG = 3'b101,
    OP_BRANCH_ON_CARRY = 3'b110
  } acbx_op_t;
endpackage : acbx_pkg

// [src/acbx_alu.sv]
// Eight-bit adder and AND unit with status flag generation
`timescale 1ns/1ps
`include "acbx_params.svh"
module acbx_alu (
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic cin,
  input wire logic is_and,
  output logic [7:0] res,
  output logic [4:0] flags
);
  wire [8:0] sum;
  wire [4:0] low_sum;
  assign sum = {1'b0, a} + {1'b0, b} + {8'h00, cin};
  assign low_sum = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
  assign res = is_and ? (a & b) : sum[7:0];

  always_comb begin
    flags = 5'h00;
    flags[`ACBX_FLG_C] = ~is_and & sum[8];
    flags[`ACBX_FLG_DC] = ~is_and & low_sum[4];
    // Signed overflow: like-signed operands giving a result of the other sign
    flags[`ACBX_FLG_OV] = ~is_and & (a[7] == b[7]) & (sum[7] != a[7]);
    flags[`ACBX_FLG_Z] = (res == 8'h00);
    flags[`ACBX_FLG_N] = res[7];
  end
endmodule : acbx_alu

// [src/acbx_exec.sv]
// Execution slice: decode, four-phase sequencing, data memory access, AXI4-Lite registers
//
// Design decisions made here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`include "acbx_params.svh"
module acbx_exec #(
  parameter int PC_W = 21,
  parameter int ADDR_W = 8
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic fetch_valid,
  input wire logic [15:0] fetch_instr,
  output logic fetch_ready,
  output logic [PC_W-1:0] pc_out,
  output logic pc_load,
  output acbx_pkg::acbx_phase_t phase,
  output logic [11:0] dmem_addr,
  output logic dmem_rd_en,
  input wire logic [7:0] dmem_rdata,
  output logic dmem_wr_en,
  output logic [7:0] dmem_wdata,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);
  import acbx_pkg::*;

  function automatic acbx_op_t decode_op(input logic [15:0] iw);
    acbx_op_t op;
    op = OP_NONE;
    if (iw[15:8] == `ACBX_HI_ADD_LIT) op = OP_ADD_LITERAL;
    else if (iw[15:8] == `ACBX_HI_AND_LIT) op = OP_AND_LITERAL;
    else if (iw[15:8] == `ACBX_HI_BR_C) op = OP_BRANCH_ON_CARRY;
    else if (iw[15:10] == `ACBX_TOP_ADD_REG) op = OP_ADD_REG;
    else if (iw[15:10] == `ACBX_TOP_ADDC_REG) op = OP_ADD_REG_CARRY;
    else if (iw[15:10] == `ACBX_TOP_AND_REG) op = OP_AND_REG;
    return op;
  endfunction : decode_op

  function automatic logic is_reg_op(input acbx_op_t op);
    return (op == OP_ADD_REG) || (op == OP_ADD_REG_CARRY) || (op == OP_AND_REG);
  endfunction : is_reg_op

  function automatic logic is_and_op(input acbx_op_t op);
    return (op == OP_AND_LITERAL) || (op == OP_AND_REG);
  endfunction : is_and_op

  function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction : merge_strb

  acbx_state_t state_ff;
  acbx_phase_t phase_ff;
  acbx_op_t op_ff;
  logic [15:0] ir_ff;
  logic [7:0] work_ff;
  logic [4:0] flags_ff;
  logic [3:0] bank_ff;
  logic [PC_W-1:0] pc_ff;
  logic [PC_W-1:0] tgt_ff;
  logic [7:0] res_ff;
  logic [4:0] rflags_ff;
  logic taken_ff;
  logic last_taken_ff;
  logic unk_ff;
  logic fetch_ready_ff;
  logic pc_load_ff;
  logic [11:0] dmem_addr_ff;
  logic dmem_rd_en_ff;
  logic dmem_wr_en_ff;
  logic [7:0] dmem_wdata_ff;
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic aw_held_ff;
  logic w_held_ff;

  wire take = fetch_valid & fetch_ready_ff;
  wire in_exec = (state_ff == ST_EXEC);
  wire at_q1 = in_exec & (phase_ff == PH_Q1);
  wire at_q3 = in_exec & (phase_ff == PH_Q3);
  wire at_q4 = in_exec & (phase_ff == PH_Q4);
  wire dest_file = ir_ff[`ACBX_DEST_BIT];
  wire [7:0] file_addr = ir_ff[7:0];
  // Access bank splits the 8-bit field between a low and a high bank
  wire [3:0] acc_bank = (file_addr < `ACBX_ACC_SPLIT) ? `ACBX_ACC_LO_BANK : `ACBX_ACC_HI_BANK;
  wire [3:0] use_bank = ir_ff[`ACBX_BANK_BIT] ? bank_ff : acc_bank;
  wire [11:0] data_addr = {use_bank, file_addr};
  wire [7:0] operand_b = is_reg_op(op_ff) ? dmem_rdata : ir_ff[7:0];
  wire carry_in = (op_ff == OP_ADD_REG_CARRY) & flags_ff[`ACBX_FLG_C];
  wire [7:0] alu_res;
  wire [4:0] alu_flags;
  wire [PC_W-1:0] off2 = PC_W'({{(PC_W-8){ir_ff[7]}}, ir_ff[7:0]}) <<< 1;
  wire [PC_W-1:0] br_target = pc_ff + off2;
  wire [4:0] logic_flags = (flags_ff & ~`ACBX_LOGIC_MASK) | (rflags_ff & `ACBX_LOGIC_MASK);

  acbx_alu u_alu (
    .a(work_ff),
    .b(operand_b),
    .cin(carry_in),
    .is_and(is_and_op(op_ff)),
    .res(alu_res),
    .flags(alu_flags)
  );

  // Register writes are refused while an instruction is in flight,
  // so software never races the core on shared state
  wire wr_fire = aw_held_ff & w_held_ff & ~bvalid_ff;
  wire sw_ok = (state_ff == ST_IDLE);
  wire hit_work = (awaddr_ff == ADDR_W'(`ACBX_REG_WORK));
  wire hit_flags = (awaddr_ff == ADDR_W'(`ACBX_REG_FLAGS));
  wire hit_bank = (awaddr_ff == ADDR_W'(`ACBX_REG_BANK));
  wire hit_pc = (awaddr_ff == ADDR_W'(`ACBX_REG_PC));
  wire hit_exec = (awaddr_ff == ADDR_W'(`ACBX_REG_EXEC));
  wire wr_map = hit_work | hit_flags | hit_bank | hit_pc | hit_exec;
  wire wr_do = wr_fire & wr_map & sw_ok;
  wire [31:0] wmerged_work = merge_strb({24'h000000, work_ff}, wdata_ff, wstrb_ff);
  wire [31:0] wmerged_flags = merge_strb({27'h0, flags_ff}, wdata_ff, wstrb_ff);
  wire [31:0] wmerged_bank = merge_strb({28'h0, bank_ff}, wdata_ff, wstrb_ff);
  wire [31:0] wmerged_pc = merge_strb(32'(pc_ff), wdata_ff, wstrb_ff);
  wire unk_clr = wr_do & hit_exec & wstrb_ff[0] & wdata_ff[`ACBX_EXEC_UNK];
  wire unk_set = at_q1 & (op_ff == OP_NONE);
  wire [31:0] exec_word = {29'h0, unk_ff, last_taken_ff, ~sw_ok};
  wire ar_take = s_axi_arvalid & arready_ff;
  wire ar_map = (s_axi_araddr == ADDR_W'(`ACBX_REG_WORK)) |
                (s_axi_araddr == ADDR_W'(`ACBX_REG_FLAGS)) |
                (s_axi_araddr == ADDR_W'(`ACBX_REG_BANK)) |
                (s_axi_araddr == ADDR_W'(`ACBX_REG_PC)) |
                (s_axi_araddr == ADDR_W'(`ACBX_REG_EXEC));
  wire [31:0] rd_mux =
    (s_axi_araddr == ADDR_W'(`ACBX_REG_WORK)) ? {24'h000000, work_ff} :
    (s_axi_araddr == ADDR_W'(`ACBX_REG_FLAGS)) ? {27'h0, flags_ff} :
    (s_axi_araddr == ADDR_W'(`ACBX_REG_BANK)) ? {28'h0, bank_ff} :
    (s_axi_araddr == ADDR_W'(`ACBX_REG_PC)) ? 32'(pc_ff) :
    (s_axi_araddr == ADDR_W'(`ACBX_REG_EXEC)) ? exec_word : 32'h0000_0000;

  // Sequencer: one idle cycle to accept, then Q1..Q4, plus Q1..Q4 of no-op after a jump
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state_ff <= ST_IDLE;
      phase_ff <= PH_Q1;
      op_ff <= OP_NONE;
      ir_ff <= 16'h0000;
      fetch_ready_ff <= 1'b1;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (take) begin
            ir_ff <= fetch_instr;
            op_ff <= decode_op(fetch_instr);
            state_ff <= ST_EXEC;
            phase_ff <= PH_Q1;
            fetch_ready_ff <= 1'b0;
          end
        end
        ST_EXEC: begin
          phase_ff <= acbx_phase_t'(phase_ff + 2'b01);
          if (phase_ff == PH_Q4) begin
            state_ff <= taken_ff ? ST_NOPC : ST_IDLE;
            fetch_ready_ff <= ~taken_ff;
          end
        end
        ST_NOPC: begin
          phase_ff <= acbx_phase_t'(phase_ff + 2'b01);
          if (phase_ff == PH_Q4) begin
            state_ff <= ST_IDLE;
            fetch_ready_ff <= 1'b1;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
          fetch_ready_ff <= 1'b1;
        end
      endcase
    end
  end

  // Data memory port: read issued in Q2, write-back held during Q4
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      dmem_addr_ff <= 12'h000;
      dmem_rd_en_ff <= 1'b0;
      dmem_wr_en_ff <= 1'b0;
      dmem_wdata_ff <= 8'h00;
    end else begin
      dmem_rd_en_ff <= at_q1 & is_reg_op(op_ff);
      dmem_wr_en_ff <= at_q3 & is_reg_op(op_ff) & dest_file;
      if (at_q1) dmem_addr_ff <= data_addr;
      if (at_q3) dmem_wdata_ff <= alu_res;
    end
  end

  // Q3 processing result and branch decision
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      res_ff <= 8'h00;
      rflags_ff <= 5'h00;
      taken_ff <= 1'b0;
      tgt_ff <= '0;
      pc_load_ff <= 1'b0;
    end else begin
      if (at_q3) begin
        res_ff <= alu_res;
        rflags_ff <= alu_flags;
        tgt_ff <= br_target;
      end
      if (state_ff == ST_IDLE) taken_ff <= 1'b0;
      else if (at_q3) taken_ff <= (op_ff == OP_BRANCH_ON_CARRY) & flags_ff[`ACBX_FLG_C];
      pc_load_ff <= at_q3 & (op_ff == OP_BRANCH_ON_CARRY) & flags_ff[`ACBX_FLG_C];
    end
  end

  // Architectural state: core write-back at the end of Q4, software only when idle
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      work_ff <= `ACBX_WORK_RST;
      flags_ff <= `ACBX_FLAGS_RST;
      bank_ff <= `ACBX_BANK_RST;
      pc_ff <= PC_W'(`ACBX_PC_RST);
      last_taken_ff <= 1'b0;
      unk_ff <= 1'b0;
    end else begin
      if (at_q1) pc_ff <= pc_ff + PC_W'(`ACBX_PC_STEP);
      else if (pc_load_ff) pc_ff <= tgt_ff;
      else if (wr_do & hit_pc) pc_ff <= wmerged_pc[PC_W-1:0];
      if (at_q4 && op_ff != OP_NONE && op_ff != OP_BRANCH_ON_CARRY) begin
        if (!is_reg_op(op_ff) || !dest_file) work_ff <= res_ff;
        flags_ff <= is_and_op(op_ff) ? logic_flags : rflags_ff;
      end else begin
        if (wr_do & hit_work) work_ff <= wmerged_work[7:0];
        if (wr_do & hit_flags) flags_ff <= wmerged_flags[4:0];
      end
      if (wr_do & hit_bank) bank_ff <= wmerged_bank[3:0];
      if (at_q4) last_taken_ff <= taken_ff;
      // A new unknown opcode wins over a clear in the same cycle
      if (unk_set) unk_ff <= 1'b1;
      else if (unk_clr) unk_ff <= 1'b0;
    end
  end

  // AXI4-Lite write channel: address and data taken in any order
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `ACBX_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && awready_ff) begin
        awaddr_ff <= s_axi_awaddr;
        aw_held_ff <= 1'b1;
        awready_ff <= 1'b0;
      end
      if (s_axi_wvalid && wready_ff) begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
        w_held_ff <= 1'b1;
        wready_ff <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= (wr_map && sw_ok) ? `ACBX_RESP_OKAY : `ACBX_RESP_SLVERR;
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
      end
      if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff <= 1'b1;
      end
    end
  end

  // AXI4-Lite read channel: data one cycle after the address is taken
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= `ACBX_RESP_OKAY;
    end else begin
      if (ar_take) begin
        arready_ff <= 1'b0;
        rvalid_ff <= 1'b1;
        rdata_ff <= rd_mux;
        rresp_ff <= ar_map ? `ACBX_RESP_OKAY : `ACBX_RESP_SLVERR;
      end else if (rvalid_ff && s_axi_rready) begin
        rvalid_ff <= 1'b0;
        arready_ff <= 1'b1;
      end
    end
  end

  assign fetch_ready = fetch_ready_ff;
  assign pc_out = pc_ff;
  assign pc_load = pc_load_ff;
  assign phase = phase_ff;
  assign dmem_addr = dmem_addr_ff;
  assign dmem_rd_en = dmem_rd_en_ff;
  assign dmem_wr_en = dmem_wr_en_ff;
  assign dmem_wdata = dmem_wdata_ff;
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence s_four_phases;
    phase_ff == PH_Q1 ##1 phase_ff == PH_Q2 ##1 phase_ff == PH_Q3 ##1 phase_ff == PH_Q4;
  endsequence
  sequence s_br_start(logic c);
    at_q1 && op_ff == OP_BRANCH_ON_CARRY && flags_ff[`ACBX_FLG_C] == c;
  endsequence

  a_phase_order: assert property (at_q1 |-> s_four_phases)
    else $error("phases out of order");
  a_lit_add: assert property (at_q4 && op_ff == OP_ADD_LITERAL |=>
    work_ff == 8'($past(work_ff) + $past(ir_ff[7:0])))
    else $error("literal add result wrong");
  a_addc_sum: assert property (at_q3 && op_ff == OP_ADD_REG_CARRY |=>
    res_ff == 8'($past(work_ff) + $past(dmem_rdata) + {7'h00, $past(flags_ff[0])}))
    else $error("add with carry sum wrong");
  a_add_flags: assert property (at_q4 && op_ff inside {OP_ADD_LITERAL, OP_ADD_REG,
    OP_ADD_REG_CARRY} |=> flags_ff == $past(rflags_ff))
    else $error("add flags not updated");
  a_and_keep: assert property (at_q4 && is_and_op(op_ff) |=>
    flags_ff[1:0] == $past(flags_ff[1:0]) && flags_ff[3] == $past(flags_ff[3]))
    else $error("logic op changed carry flags");
  a_dest_file: assert property (at_q4 && is_reg_op(op_ff) && dest_file |->
    dmem_wr_en_ff && dmem_wdata_ff == res_ff ##1 work_ff == $past(work_ff))
    else $error("file destination not honoured");
  a_bank_pick: assert property (dmem_rd_en_ff |-> dmem_addr_ff ==
    {ir_ff[8] ? bank_ff : acc_bank, ir_ff[7:0]} && phase_ff == PH_Q2)
    else $error("data address wrong");
  a_br_taken: assert property (s_br_start(1'b1) |->
    (!fetch_ready_ff)[*8] ##1 fetch_ready_ff)
    else $error("taken branch not two cycles");
  a_br_fall: assert property (s_br_start(1'b0) |->
    (!fetch_ready_ff && !pc_load_ff)[*4] ##1 fetch_ready_ff)
    else $error("untaken branch misbehaved");
  a_br_target: assert property (s_br_start(1'b1) |-> ##4
    pc_ff == PC_W'($past(pc_ff, 4) + 2 + ($signed({{(PC_W-8){$past(ir_ff[7], 4)}},
    $past(ir_ff[7:0], 4)}) <<< 1)))
    else $error("branch target wrong");
endmodule : acbx_exec

// [tb/acbx_dmem_model.sv]
// Data memory partner: synchronous read, write on the enable edge
`timescale 1ns/1ps
module acbx_dmem_model (
  input wire logic mclk,
  input wire logic [11:0] dmem_addr,
  input wire logic dmem_rd_en,
  input wire logic dmem_wr_en,
  input wire logic [7:0] dmem_wdata,
  output logic [7:0] dmem_rdata
);
  logic [7:0] mem [0:4095];
  initial dmem_rdata = 8'hA5;
  always @(posedge mclk) begin
    if (dmem_rd_en) begin
      dmem_rdata <= mem[dmem_addr];
    end else begin
      // Stale data would hide a late sample in the core, so scramble it
      dmem_rdata <= ~dmem_rdata;
    end
    if (dmem_wr_en) begin
      mem[dmem_addr] <= dmem_wdata;
    end
  end
endmodule : acbx_dmem_model

// [tb/tb.sv]
// Self-checking bench for the add/and/branch-on-carry execution slice
`timescale 1ns/1ps
`include "acbx_params.svh"
module tb;
  import acbx_pkg::*;
  logic mclk, nrst, fetch_valid, fetch_ready, pc_load, rd_en, wr_en;
  logic [15:0] fetch_instr, ins;
  logic [20:0] pc_out;
  acbx_phase_t phase;
  logic [11:0] dm_addr;
  logic [7:0] dm_rdata, dm_wdata, awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, seed, rd, x;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic [7:0] offs [0:2] = '{8'h80, 8'h7F, 8'h00};
  int n_mismatch, tests_run, w, c, dc, z, ov, ng, bank, pc, last_addr, i;
  int shadow [0:4095];
  int exp_q [$];
  acbx_exec dut (.mclk(mclk), .nrst(nrst), .fetch_valid(fetch_valid), .fetch_instr(fetch_instr),
    .fetch_ready(fetch_ready), .pc_out(pc_out), .pc_load(pc_load), .phase(phase),
    .dmem_addr(dm_addr), .dmem_rd_en(rd_en), .dmem_rdata(dm_rdata), .dmem_wr_en(wr_en),
    .dmem_wdata(dm_wdata), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp));
  acbx_dmem_model mem_i (.mclk(mclk), .dmem_addr(dm_addr), .dmem_rd_en(rd_en),
    .dmem_wr_en(wr_en), .dmem_wdata(dm_wdata), .dmem_rdata(dm_rdata));
  always #50 mclk = ~mclk;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic [31:0] flg();
    return c | dc << 1 | z << 2 | ov << 3 | ng << 4;
  endfunction : flg

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic wait_expired();
    n_mismatch++;
    $display("Error at %0t: wait ran out, got %h expected %h", $time, 0, 1);
    report_and_stop();
  endtask : wait_expired

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int k;
    @(posedge mclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge mclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    resp = bresp;
    bready <= 1'b0;
    if (k == 50) wait_expired();
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    int k;
    @(posedge mclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge mclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
    if (k == 50) wait_expired();
  endtask : axi_rd

  task automatic set_flags(input logic [4:0] v);
    axi_wr(`ACBX_REG_FLAGS, {27'h0, v}, 4'hF);
    c = v[0];
    dc = v[1];
    z = v[2];
    ov = v[3];
    ng = v[4];
  endtask : set_flags

  task automatic model_op(input logic [15:0] op, output int cy, output int nr, output int nw,
                          output int nl);
    int a, r, ci, hi, top;
    bit is_lit, is_reg, is_and;
    hi = op[15:8];
    top = op[15:10];
    is_lit = hi == `ACBX_HI_ADD_LIT || hi == `ACBX_HI_AND_LIT;
    is_reg = top == `ACBX_TOP_ADD_REG || top == `ACBX_TOP_ADDC_REG || top == `ACBX_TOP_AND_REG;
    is_and = hi == `ACBX_HI_AND_LIT || top == `ACBX_TOP_AND_REG;
    last_addr = op[8] ? bank * 256 + op[7:0] : (op[7] ? 15 * 256 : 0) + op[7:0];
    // Four phase edges after the take edge; a taken branch adds four more for the no-op
    cy = 4;
    nr = is_reg;
    nw = is_reg && op[9];
    nl = 0;
    pc = (pc + 2) & 32'h1FFFFF;
    if (hi == `ACBX_HI_BR_C && c) begin
      // Kept apart from the mask so the offset stays sign-extended
      pc = pc + 2 * $signed(op[7:0]);
      pc = pc & 32'h1FFFFF;
      cy = 8;
      nl = 1;
    end
    if (is_lit || is_reg) begin
      a = is_reg ? shadow[last_addr] : op[7:0];
      ci = top == `ACBX_TOP_ADDC_REG ? c : 0;
      r = is_and ? w & a : w + a + ci;
      if (!is_and) begin
        c = r >> 8;
        dc = ((w & 15) + (a & 15) + ci) >> 4;
        ov = (w >> 7) == (a >> 7) && ((r >> 7) & 1) != (w >> 7);
        r = r & 255;
      end
      ng = r >> 7;
      z = r == 0;
      if (nw) shadow[last_addr] = r;
      else w = r;
    end
  endtask : model_op

  task automatic run_op(input logic [15:0] op, output int cy, output int nr, output int nw,
                        output int nl);
    int k;
    cy = 0;
    nr = 0;
    nw = 0;
    nl = 0;
    @(posedge mclk);
    fetch_valid <= 1'b1;
    fetch_instr <= op;
    for (k = 0; k < 20; k++) begin
      @(posedge mclk);
      if (fetch_ready === 1'b1) break;
    end
    if (k == 20) wait_expired();
    fetch_valid <= 1'b0;
    fetch_instr <= 16'(rnd());
    for (k = 0; k < 20; k++) begin
      @(posedge mclk);
      #1;
      cy++;
      if (fetch_ready === 1'b1) break;
      nr += rd_en === 1'b1 && phase === PH_Q2;
      nw += wr_en === 1'b1 && phase === PH_Q4;
      nl += pc_load === 1'b1 && phase === PH_Q4;
    end
    if (k == 20) wait_expired();
  endtask : run_op

  task automatic step(input logic [15:0] op);
    int ec, er, ew, el, gc, gr, gw, gl;
    model_op(op, ec, er, ew, el);
    exp_q.push_back(w);
    exp_q.push_back(flg());
    run_op(op, gc, gr, gw, gl);
    check(gc, ec);
    check(gr, er);
    check(gw, ew);
    check(gl, el);
    check(pc_out, pc);
    check(mem_i.mem[last_addr], shadow[last_addr]);
    axi_rd(`ACBX_REG_WORK);
    check(rd, exp_q.pop_front());
    axi_rd(`ACBX_REG_FLAGS);
    check(rd, exp_q.pop_front());
  endtask : step

  initial begin
    mclk = 1'b0;
    nrst = 1'b0;
    fetch_valid = 1'b0;
    fetch_instr = 16'h0000;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    seed = 32'd11136;
    {n_mismatch, tests_run, w, c, dc, z, ov, ng, bank, pc} = '0;
    for (i = 0; i < 4096; i++) begin
      shadow[i] = rnd() & 255;
      mem_i.mem[i] = 8'(shadow[i]);
    end
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    for (i = 0; i < 5; i++) begin
      axi_rd(8'(i * 4));
      check(rd, 32'h0);
      check(resp, `ACBX_RESP_OKAY);
    end
    axi_rd(8'h14);
    check(resp, `ACBX_RESP_SLVERR);
    check(rd, 32'h0);
    axi_wr(8'h14, 32'hFFFFFFFF, 4'hF);
    check(resp, `ACBX_RESP_SLVERR);
    axi_wr(`ACBX_REG_WORK, 32'hFFFFFF3C, 4'h0);
    axi_rd(`ACBX_REG_WORK);
    check(rd, 32'h0);
    axi_wr(`ACBX_REG_WORK, 32'hFFFFFF3C, 4'hF);
    axi_rd(`ACBX_REG_WORK);
    check(rd, 32'h3C);
    w = 32'h3C;
    axi_wr(`ACBX_REG_PC, 32'h1000, 4'hF);
    pc = 32'h1000;
    $display("Register access test done");
    // Offsets at both ends of the signed range, carry set and clear
    for (i = 0; i < 6; i++) begin
      set_flags(5'(i & 1));
      step({`ACBX_HI_BR_C, offs[i / 2]});
      axi_rd(`ACBX_REG_EXEC);
      check(rd, (i & 1) * 2);
    end
    $display("Branch test done");
    for (i = 0; i < 96; i++) begin
      if (i % 8 == 0) begin
        bank = rnd() & 15;
        axi_wr(`ACBX_REG_BANK, bank, 4'hF);
        w = rnd() & 255;
        axi_wr(`ACBX_REG_WORK, w, 4'hF);
        set_flags(5'(rnd()));
      end
      x = rnd();
      ins = x[15:0];
      case ((x >> 16) % 6)
        0: ins[15:8] = `ACBX_HI_ADD_LIT;
        1: ins[15:8] = `ACBX_HI_AND_LIT;
        2: ins[15:10] = `ACBX_TOP_ADD_REG;
        3: ins[15:10] = `ACBX_TOP_ADDC_REG;
        4: ins[15:10] = `ACBX_TOP_AND_REG;
        default: ins[15:8] = `ACBX_HI_BR_C;
      endcase
      step(ins);
    end
    $display("Random instruction test done");
    step(16'hFFFF);
    axi_rd(`ACBX_REG_EXEC);
    check(rd & 32'h5, 32'h4);
    axi_wr(`ACBX_REG_EXEC, 32'h4, 4'hF);
    axi_rd(`ACBX_REG_EXEC);
    check(rd & 32'h5, 32'h0);
    $display("Unknown opcode test done");
    report_and_stop();
  end
endmodule : tb
